// ===== rtl/sonet_frame_word_aligner.sv
// Framing word aligner with byte serializer, deserializer and ordering.
// Assumes line lanes arrive one unit per clock from outside the domain
// and configuration comes from framer logic on the same clock.
`timescale 1ns/1ps
`default_nettype none
module sonet_frame_word_aligner
  import sonet_align_pkg::*;
(
  // Clock and reset.
  input wire logic mclk,
  input wire logic resetn,
  // Configuration from the framer.
  input wire logic [1:0] mode,
  input wire logic pattern_size_select,
  input wire logic [15:0] align_pattern,
  input wire logic pattern_flip,
  input wire logic tx_flip,
  input wire logic rx_flip,
  input wire logic realign,
  // Transmit words from the framer.
  input wire logic [WORD_W-1:0] tx_word,
  input wire logic tx_valid,
  output logic tx_ready,
  // Transmit lane toward the line.
  output logic [LANE_W-1:0] tx_line,
  output logic tx_line_valid,
  input wire logic tx_line_ready,
  // Receive lane from the line.
  input wire logic [LANE_W-1:0] rx_line,
  // Receive words and status toward the framer.
  output logic [WORD_W-1:0] rx_word,
  output logic rx_valid,
  output logic sync_locked,
  output logic pad_inserted
);

  typedef struct packed {
    logic [LANE_W-1:0] rx_s1;
    logic [LANE_W-1:0] rx_s2;
    logic rdy_s1;
    logic rdy_s2;
    logic [HIST_W-1:0] hist;
    align_e st;
    logic [3:0] off;
    logic locked;
    logic lock_prev;
    logic order_pend;
    logic des_ph;
    logic [LANE_W-1:0] des_lo;
    logic [WORD_W-1:0] rx_word;
    logic rx_valid;
    logic pad;
    logic ser_ph;
    logic [LANE_W-1:0] tx_line;
    logic tx_line_valid;
  } state_s;

  state_s s_q, s_d;

  ////////////////////////////////////////////////////////////////////////////
  // Transmit FIFO between the framer and the serializer.

  logic [WORD_W-1:0] f_data;
  logic f_valid, f_ready;

  // Back-pressure from the line reaches the framer through tx_ready.
  word_fifo #(
    .WIDTH(WORD_W),
    .DEPTH(FIFO_DEPTH)
  ) u_tx_fifo (
    .mclk(mclk),
    .resetn(resetn),
    .in_data(tx_word),
    .in_valid(tx_valid),
    .in_ready(tx_ready),
    .out_data(f_data),
    .out_valid(f_valid),
    .out_ready(f_ready)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Pattern compare at every bit offset.

  logic oc48, oc96, sel32;
  logic [15:0] pat16;
  logic [31:0] pat32;
  logic [7:0] pad_byte, a2_byte;
  logic [OFFSETS-1:0] hit16, hit32, cand;

  // Mode decode; the illegal code falls back to the bypass path.
  assign oc48 = (mode == MODE_OC48);
  assign oc96 = (mode == MODE_OC96);
  assign sel32 = oc96 | pattern_size_select;
  assign pat16 = pattern_flip ? rev16(align_pattern) : align_pattern;
  assign pat32 = {pat16[15:8], pat16[15:8], pat16[7:0], pat16[7:0]};
  assign pad_byte = pat16[15:8];
  assign a2_byte = pat16[7:0];

  // Oldest bits sit at the top of the history, so the match index is
  // where the pattern ends; the pattern length is a whole number of lanes
  // and therefore it also starts on the new boundary.
  for (genvar k = 0; k < OFFSETS; k++) begin : g_off
    assign hit16[k] = (s_q.hist[k +: 16] == pat16);
    assign hit32[k] = (s_q.hist[k +: 32] == pat32);
    assign cand[k] = (sel32 ? hit32[k] : hit16[k]) && (oc96 || (k < 8));
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic for the whole block.

  always_comb begin
    logic [15:0] al;
    logic [7:0] b;
    logic [31:0] w;
    logic [31:0] td;
    logic sent;
    s_d = s_q;
    al = s_q.hist[s_q.off +: 16];
    b = al[7:0];
    w = '0;
    td = tx_flip ? rev_bytes32(f_data) : f_data;
    sent = 1'b0;
    f_ready = 1'b0;
    s_d.rx_valid = 1'b0;
    s_d.pad = 1'b0;
    s_d.tx_line_valid = 1'b0;

    // Two-flop synchronisers for everything arriving from the line.
    s_d.rx_s1 = rx_line;
    s_d.rx_s2 = s_q.rx_s1;
    s_d.rdy_s1 = tx_line_ready;
    s_d.rdy_s2 = s_q.rdy_s1;

    // Lanes are 8 bits wide except OC-96, which takes 16 a cycle.
    if (oc96) begin
      s_d.hist = {s_q.hist[31:0], s_q.rx_s2};
    end else begin
      s_d.hist = {s_q.hist[39:0], s_q.rx_s2[7:0]};
    end

    // Manual aligner: hunt once, then hold the boundary until realign.
    unique case (s_q.st)
      ST_SEARCH: begin
        s_d.locked = 1'b0;
        for (int k = OFFSETS - 1; k >= 0; k--) begin
          if (cand[k]) begin
            s_d.off = k[3:0];
            s_d.st = ST_LOCKED;
            s_d.locked = 1'b1;
          end
        end
      end
      ST_LOCKED: begin
        if (realign) begin
          s_d.st = ST_SEARCH;
          s_d.locked = 1'b0;
        end
      end
    endcase

    // Byte ordering arms on each rising edge of lock in OC-48 only.
    s_d.lock_prev = s_q.locked;
    if (s_q.locked && !s_q.lock_prev && oc48) begin
      s_d.order_pend = 1'b1;
    end
    if (!s_q.locked) begin
      s_d.des_ph = 1'b0;
    end

    // Receive deserializer; earlier unit lands in the low half.
    if (s_q.locked) begin
      if (oc96) begin
        if (!s_q.des_ph) begin
          s_d.des_lo = al;
          s_d.des_ph = 1'b1;
        end else begin
          w = {al, s_q.des_lo};
          s_d.des_ph = 1'b0;
          s_d.rx_valid = 1'b1;
        end
      end else if (oc48) begin
        if (!s_q.des_ph) begin
          s_d.des_lo = {8'h00, b};
          s_d.des_ph = 1'b1;
        end else if (s_q.order_pend &&
                     s_q.des_lo[7:0] != a2_byte) begin
          // Filler goes first so the stray byte becomes the high half
          // and the pairing slips by exactly one byte.
          w = {16'h0000, s_q.des_lo[7:0], pad_byte};
          s_d.des_lo = {8'h00, b};
          s_d.des_ph = 1'b1;
          s_d.rx_valid = 1'b1;
          s_d.pad = 1'b1;
          s_d.order_pend = 1'b0;
        end else begin
          w = {16'h0000, b, s_q.des_lo[7:0]};
          s_d.des_ph = 1'b0;
          s_d.rx_valid = 1'b1;
          s_d.order_pend = 1'b0;
        end
      end else begin
        w = {24'h000000, b};
        s_d.rx_valid = 1'b1;
      end
    end
    if (s_d.rx_valid) begin
      s_d.rx_word = rx_flip ? rev_bytes32(w) : w;
    end

    // Transmit serializer, paced by the synchronised line ready.
    if (!oc48 && !oc96) begin
      s_d.ser_ph = 1'b0;
    end
    if (s_q.rdy_s2 && f_valid) begin
      sent = 1'b1;
      if (oc96) begin
        s_d.tx_line = s_q.ser_ph ? td[31:16] : td[15:0];
        f_ready = s_q.ser_ph;
        s_d.ser_ph = !s_q.ser_ph;
      end else if (oc48) begin
        s_d.tx_line = {8'h00, s_q.ser_ph ? td[15:8] : td[7:0]};
        f_ready = s_q.ser_ph;
        s_d.ser_ph = !s_q.ser_ph;
      end else begin
        s_d.tx_line = {8'h00, td[7:0]};
        f_ready = 1'b1;
      end
    end
    s_d.tx_line_valid = sent;
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register.

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs straight from the state flops.
  assign tx_line = s_q.tx_line;
  assign tx_line_valid = s_q.tx_line_valid;
  assign rx_word = s_q.rx_word;
  assign rx_valid = s_q.rx_valid;
  assign sync_locked = s_q.locked;
  assign pad_inserted = s_q.pad;

  ////////////////////////////////////////////////////////////////////////////
  // Checks next to the logic they guard.

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!resetn);

  // Lock only follows a real match while searching.
  lock_needs_match_a: assert property (
    $rose(sync_locked) |-> $past(|cand) && $past(s_q.st == ST_SEARCH))
    else $error("lock rose without a pattern match");

  // OC-96 always locks on the double pair.
  oc96_double_pair_a: assert property (
    $rose(sync_locked) && $past(oc96) |-> $past(sel32))
    else $error("OC-96 lock used the short pattern");

  // A short-pattern match locks on the next edge.
  size_select_a: assert property (
    s_q.st == ST_SEARCH && !oc96 && !pattern_size_select && !realign
    && |cand |=> sync_locked)
    else $error("16-bit match did not lock");

  // OC-12 delivers one byte every locked cycle.
  oc12_bypass_a: assert property (
    sync_locked && !oc48 && !oc96 && !realign |=> rx_valid)
    else $error("OC-12 bypass dropped a byte");

  // OC-48 words come at half rate unless a filler was just inserted.
  oc48_half_rate_a: assert property (
    rx_valid && !pad_inserted && oc48 ##1 oc48 && sync_locked |-> !rx_valid)
    else $error("OC-48 deserializer ran at full rate");

  // The filler carries the first framing byte of the pattern.
  pad_value_a: assert property (
    pad_inserted |-> rx_word[7:0] == ($past(rx_flip) ?
      rev8($past(pad_byte)) : $past(pad_byte)))
    else $error("filler byte is not the first framing byte");

  // Insertion happens only when armed by a lock edge in OC-48.
  order_trigger_a: assert property (
    pad_inserted |-> $past(s_q.order_pend) && $past(oc48))
    else $error("filler inserted without an ordering trigger");

  // A filler is only due when the held low byte missed the second byte;
  // a right order must pass through untouched.
  pad_on_mismatch_a: assert property (
    pad_inserted |-> $past(s_q.des_lo[7:0]) != $past(a2_byte))
    else $error("filler inserted although the byte order was right");

  // OC-48 pops one word per two bytes sent.
  tx_two_bytes_a: assert property (
    oc48 && f_ready |-> s_q.ser_ph ##1 tx_line_valid && !s_q.ser_ph)
    else $error("OC-48 serializer popped on the first byte");

  // OC-12 sends the flipped or plain low byte of the word.
  tx_bit_order_a: assert property (
    f_ready && f_valid && !oc48 && !oc96 |=> tx_line[7:0] ==
      ($past(tx_flip) ? rev8($past(f_data[7:0])) : $past(f_data[7:0])))
    else $error("transmit byte has the wrong bit order");

  // Main scenarios.
  lock_oc48_c: cover property (oc48 && $rose(sync_locked));
  pad_insert_c: cover property (pad_inserted);
  fifo_full_c: cover property (!tx_ready ##1 tx_ready);
  oc96_word_c: cover property (oc96 && rx_valid);
  oc12_word_c: cover property (!oc48 && !oc96 && rx_valid);

endmodule
`default_nettype wire

// ===== rtl/sonet_align_pkg.sv
// Constants, types and helpers shared by the framing aligner datapath.
// Assumes a single 10 MHz clock domain and no register bus.
package sonet_align_pkg;

  // Line configurations; code 2'b11 is illegal and behaves as OC-12.
  typedef enum logic [1:0] {
    MODE_OC12 = 2'b00,
    MODE_OC48 = 2'b01,
    MODE_OC96 = 2'b10
  } mode_e;

  // Manual aligner states.
  typedef enum logic {
    ST_SEARCH = 1'b0,
    ST_LOCKED = 1'b1
  } align_e;

  // Framing bytes and the reference alignment patterns.
  localparam logic [7:0] FIRST_FRAMING_BYTE = 8'hF6;
  localparam logic [7:0] SECOND_FRAMING_BYTE = 8'h28;
  localparam logic [15:0] PATTERN_MSB_FLIP = 16'hF628;
  localparam logic [15:0] PATTERN_MSB_NOFLIP = 16'h146F;
  localparam logic [15:0] PATTERN_LSB_NOFLIP = 16'h28F6;
  localparam logic [15:0] PATTERN_RESET = PATTERN_MSB_FLIP;

  // Line figures: framing runs, frame period and rates.
  localparam int OC12_RUN = 12;
  localparam int OC48_RUN = 48;
  localparam int OC96_RUN = 96;
  localparam int FRAME_PERIOD_US = 125;
  localparam int CLK_MHZ = 10;
  localparam int FRAME_CYCLES = FRAME_PERIOD_US * CLK_MHZ;
  localparam real OC12_MBPS = 622.0;
  localparam real OC48_MBPS = 2488.32;
  localparam real OC96_MBPS = 4967.0;

  // Datapath sizes.
  localparam int LANE_W = 16;
  localparam int WORD_W = 32;
  localparam int HIST_W = 48;
  localparam int OFFSETS = 16;
  localparam int FIFO_DEPTH = 4;

  // Reverses the bit order of one byte.
  function automatic logic [7:0] rev8(input logic [7:0] v);
    logic [7:0] r;
    for (int i = 0; i < 8; i++) begin
      r[i] = v[7-i];
    end
    return r;
  endfunction

  // Reverses a whole 16-bit pattern.
  function automatic logic [15:0] rev16(input logic [15:0] v);
    return {rev8(v[7:0]), rev8(v[15:8])};
  endfunction

  // Reverses each byte of a word in place.
  function automatic logic [31:0] rev_bytes32(input logic [31:0] v);
    return {rev8(v[31:24]), rev8(v[23:16]), rev8(v[15:8]), rev8(v[7:0])};
  endfunction

endpackage

// ===== rtl/word_fifo.sv
// Small synchronous FIFO with valid/ready on both sides.
// Assumes DEPTH is a power of two and one clock for both sides.
`timescale 1ns/1ps
`default_nettype none
module word_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 4
) (
  // Clock and reset.
  input wire logic mclk,
  input wire logic resetn,
  // Filling side.
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  // Draining side.
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0] wr;
    logic [PW-1:0] rd;
    logic [CW-1:0] cnt;
    logic ready;
    logic valid;
  } fifo_s;

  fifo_s s_q, s_d;
  logic push, pop;

  // Flags are registered so both handshakes come straight from flops.
  always_comb begin
    s_d = s_q;
    push = in_valid && s_q.ready;
    pop = out_ready && s_q.valid;
    if (push) begin
      s_d.mem[s_q.wr] = in_data;
      s_d.wr = s_q.wr + PW'(1);
    end
    if (pop) begin
      s_d.rd = s_q.rd + PW'(1);
    end
    s_d.cnt = s_q.cnt + CW'(push) - CW'(pop);
    s_d.ready = (s_d.cnt != CW'(DEPTH));
    s_d.valid = (s_d.cnt != CW'(0));
  end

  // State register.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      s_q <= '0;
      s_q.ready <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign in_ready = s_q.ready;
  assign out_valid = s_q.valid;
  assign out_data = s_q.mem[s_q.rd];
endmodule
`default_nettype wire

// ===== verification/line_far_end.sv
// Far line end: framed receive stream and transmit-side line readiness.
// Assumes the aligner takes one rx_line unit on every mclk edge.
`timescale 1ns/1ps
`default_nettype none
module line_far_end
  import sonet_align_pkg::*;
(
  // Clock and reset.
  input wire logic mclk,
  input wire logic resetn,
  // Line setup from the bench.
  input wire logic [1:0] mode,
  input wire logic [15:0] data_a,
  input wire logic [15:0] data_b,
  input wire logic stall,
  // Lanes facing the aligner.
  output logic [LANE_W-1:0] rx_line,
  output logic tx_line_ready
);
  int pos;
  int run;
  logic [15:0] f1;
  logic [15:0] f2;
  ////////////////////////////////////////////////////////////////////////
  // Framing runs and bytes follow the line rate; unused upper byte noisy.
  always_comb begin
    run = (mode == MODE_OC48) ? OC48_RUN :
      (mode == MODE_OC96) ? OC96_RUN / 2 : OC12_RUN;
    // The run counts lanes; an OC-96 lane carries two framing bytes.
    f1 = (mode == MODE_OC96) ? {2{FIRST_FRAMING_BYTE}} :
      {8'hC3, FIRST_FRAMING_BYTE};
    f2 = (mode == MODE_OC96) ? {2{SECOND_FRAMING_BYTE}} :
      {8'h3C, SECOND_FRAMING_BYTE};
  end
  // Frames repeat at a fixed period, so framing recurs at equal spacing.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      pos <= 0;
      rx_line <= 16'h0000;
    end else begin
      pos <= (pos == FRAME_CYCLES - 1) ? 0 : pos + 1;
      if (pos < run) begin
        rx_line <= f1;
      end else if (pos < 2 * run) begin
        rx_line <= f2;
      end else begin
        rx_line <= pos[0] ? data_b : data_a;
      end
    end
  end
  // The line stalls only when the bench asks it to.
  assign tx_line_ready = ~stall;
endmodule
`default_nettype wire

// ===== verification/test_sonet_frame_word_aligner.sv
// Self-checking bench for the framing aligner, with a far line model.
// Assumes one 10 MHz clock and that each scenario starts from reset.
`timescale 1ns/1ps
`default_nettype none
`define CHECK(g, e) begin cmp_count++; if ((g) !== (e)) begin n_fail++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end
module test_sonet_frame_word_aligner
  import sonet_align_pkg::*;
;
  logic mclk = 0, resetn = 0, pss = 0, pflip = 0, txf = 0, rxf = 0;
  logic realign = 0, tx_valid = 0, tx_ready, tx_line_valid, stall = 1;
  logic rx_valid, sync_locked, pad_inserted, tx_line_ready;
  logic [1:0] mode = 2'h0;
  logic [15:0] pat = 16'hF628, da = 16'h0000, db = 16'h0000;
  logic [15:0] tx_line, rx_line;
  logic [31:0] tx_word = 32'h0, rx_word;
  logic [15:0] txq[$];
  int n_fail = 0, cmp_count = 0, n_pad = 0;
  sonet_frame_word_aligner DUT (.mclk(mclk), .resetn(resetn),
    .mode(mode), .pattern_size_select(pss), .align_pattern(pat),
    .pattern_flip(pflip), .tx_flip(txf), .rx_flip(rxf), .realign(realign),
    .tx_word(tx_word), .tx_valid(tx_valid), .tx_ready(tx_ready),
    .tx_line(tx_line), .tx_line_valid(tx_line_valid),
    .tx_line_ready(tx_line_ready), .rx_line(rx_line), .rx_word(rx_word),
    .rx_valid(rx_valid), .sync_locked(sync_locked),
    .pad_inserted(pad_inserted));
  line_far_end far (.mclk(mclk), .resetn(resetn), .mode(mode),
    .data_a(da), .data_b(db), .stall(stall), .rx_line(rx_line),
    .tx_line_ready(tx_line_ready));
  ////////////////////////////////////////////////////////////////////////
  // Clock and transmit-lane capture.
  initial begin
    forever #50 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    if (tx_line_valid === 1'b1) txq.push_back(tx_line);
  end
  // Filler pulses are counted so the ordering checks see every one.
  always @(posedge mclk) begin
    if (pad_inserted === 1'b1) n_pad++;
  end
  // Verdict and run end, shared with the watchdog.
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // Reset held for six cycles; outputs are checked while it is held.
  task automatic do_reset();
    resetn = 0;
    repeat (6) @(posedge mclk);
    `CHECK({tx_ready, sync_locked, rx_valid}, 3'b100)
    #10 resetn = 1;
    txq = {};
    n_pad = 0;
  endtask
  // Waits a bounded span for lock; a frame is 1250 cycles.
  task automatic wait_lock();
    for (int i = 0; i < 3000 && sync_locked !== 1'b1; i++) @(posedge mclk);
    #10;
    `CHECK(sync_locked, 1'b1)
  endtask
  // Receive case: lock, let data flow, compare the held word.
  task automatic rx_case(input logic [1:0] m, input logic ps, pf, rf,
    input logic [15:0] p, a, b, input logic [31:0] msk, exp);
    mode = m; pss = ps; pflip = pf; rxf = rf; pat = p; da = a; db = b;
    do_reset();
    wait_lock();
    repeat (400) @(posedge mclk);
    #10 `CHECK(rx_word & msk, exp)
  endtask
  // Transmit case: fill against a stalled line, then drain and compare.
  task automatic tx_case(input logic [1:0] m, input logic tf,
    input logic [31:0] w, input int n, input logic [15:0] u0, u1);
    int acc;
    acc = 0;
    mode = m; txf = tf; stall = 1;
    do_reset();
    tx_word = w; tx_valid = 1;
    for (int i = 0; i < 7; i++) begin
      @(posedge mclk);
      if (tx_ready === 1'b1) acc++;
      #10;
    end
    tx_valid = 0;
    `CHECK(acc, 4)
    `CHECK(txq.size(), 0)
    stall = 0;
    repeat (30) @(posedge mclk);
    #10 `CHECK(txq.size(), 4 * n)
    `CHECK(txq[0], u0)
    if (n == 2) `CHECK(txq[1], u1)
  endtask
  // Pattern 283C locks on the first data byte, so the next byte held is
  // not the second pattern byte and one filler must be slipped in.
  // Realign drops lock at once and the next frame brings it back.
  task automatic realign_case();
    rx_case(MODE_OC48, 0, 0, 0, 16'h283C, 16'h003C, 16'h00A5,
      32'hFFFF, 16'hA53C);
    `CHECK(n_pad, 1)
    realign = 1;
    @(posedge mclk);
    #10 realign = 0;
    @(posedge mclk);
    #10 `CHECK(sync_locked, 1'b0)
    wait_lock();
    repeat (6) @(posedge mclk);
    #10 `CHECK(n_pad, 2)
  endtask
  ////////////////////////////////////////////////////////////////////////
  // Main sequence: receive patterns, rates, byte order, then transmit.
  initial begin
    rx_case(MODE_OC12, 0, 0, 0, 16'hF628, 16'h003C, 16'h003C,
      32'hFF, 8'h3C);
    rx_case(MODE_OC12, 0, 0, 1, 16'hF628, 16'h001E, 16'h001E,
      32'hFF, 8'h78);
    rx_case(MODE_OC12, 0, 1, 0, 16'h146F, 16'h0011, 16'h0011,
      32'hFF, 8'h11);
    rx_case(MODE_OC48, 1, 0, 0, 16'hF628, 16'h003C, 16'h00A5,
      32'hFFFF, 16'hA53C);
    rx_case(MODE_OC96, 0, 0, 0, 16'hF628, 16'h5AA5, 16'h5AA5,
      32'hFFFFFFFF, 32'h5AA55AA5);
    realign_case();
    tx_case(MODE_OC48, 0, 32'h0000_1234, 2, 16'h0034, 16'h0012);
    tx_case(MODE_OC96, 0, 32'h5678_9ABC, 2, 16'h9ABC, 16'h5678);
    tx_case(MODE_OC12, 1, 32'h0000_001E, 1, 16'h0078, 16'h0000);
    complete_run();
  end
  // Watchdog sized well beyond the scenarios' total length.
  initial begin
    #(40000 * 100);
    n_fail++;
    complete_run();
  end
endmodule
`default_nettype wire
